// file: pkg/fgf_consts.vh
// constants for the fine gain and equaliser filter configuration register bank
`ifndef FGF_CONSTS_VH
`define FGF_CONSTS_VH
// register indexes; byte address is four times the index
`define FGF_IDX_GAIN_A0    12'h354
`define FGF_IDX_GAIN_A1    12'h355
`define FGF_IDX_GAIN_B0    12'h356
`define FGF_IDX_GAIN_B1    12'h357
`define FGF_IDX_FILT_CFG   12'h400
`define FGF_IDX_COEFF_A0   12'h418
`define FGF_GAIN_W         5
`define FGF_N_GAIN         4
`define FGF_COEFF_W        12
`define FGF_CFG_RESET      8'h00
`define FGF_COEFF_RESET    12'h000
`define FGF_CFG_SHARE_BIT  6
`define FGF_CFG_MERGE_BIT  5
`define FGF_CFG_SCW_LSB    2
`define FGF_CFG_SCW_MSB    4
`define FGF_CFG_MODE_MSB   1
`define FGF_MODE_OFF       2'h0
`define FGF_MODE_ON        2'h2
`endif

// file: logic/fgf_regs.v
// register bank for single-channel fine gain trims and equaliser filter setup
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "fgf_consts.vh"
module fgf_regs #(
   parameter GAIN_W  = `FGF_GAIN_W,
   parameter N_GAIN  = `FGF_N_GAIN,
   parameter COEFF_W = `FGF_COEFF_W
) (
   input  wire                      clock,
   input  wire                      rst_n,
   input  wire                      wb_cyc_i,
   input  wire                      wb_stb_i,
   input  wire                      wb_we_i,
   input  wire [13:0]               wb_adr_i,
   input  wire [3:0]                wb_sel_i,
   input  wire [31:0]               wb_dat_i,
   output reg  [31:0]               wb_dat_o,
   output reg                       wb_ack_o,
   input  wire [N_GAIN*GAIN_W-1:0]  fuse_gain_i,
   output reg  [N_GAIN*GAIN_W-1:0]  fine_gain_trim_o,
   output reg                       equaliser_filter_en_o,
   output reg                       coeff_share_bit_o,
   output reg                       filter_merge_bit_o,
   output reg  [2:0]                side_weight_field_o,
   output reg  [COEFF_W-1:0]        coeff_a_tap0_o
);

   // ----------------------------------------
   // local constants
   // ----------------------------------------
   localparam integer GW        = GAIN_W;
   localparam integer GAIN_ALL  = N_GAIN * GAIN_W;
   localparam [11:0]  IDX_CFG   = `FGF_IDX_FILT_CFG;
   localparam [11:0]  IDX_COEFF = `FGF_IDX_COEFF_A0;
   localparam integer IDX_GAIN0 = `FGF_IDX_GAIN_A0;

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   wire [11:0]             idx_w;
   wire                    req_w;
   wire                    wr_w;
   wire                    rd_w;
   wire                    sel0_w;
   wire                    sel1_w;
   wire                    hit_cfg_w;
   wire                    hit_coeff_w;
   wire [N_GAIN-1:0]       hit_gain_w;
   wire [GAIN_ALL-1:0]     gain_flat_w;
   wire [1:0]              mode_w;
   wire                    share_w;
   wire                    merge_w;
   wire [2:0]              weight_w;
   wire                    mode_on_w;
   reg                     fuse_load_r;
   reg  [7:0]              cfg_r;
   reg  [7:0]              cfg_nxt;
   reg  [15:0]             coeff_r;
   reg  [15:0]             coeff_nxt;
   reg  [31:0]             rd_nxt;
   integer                 k;

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   // byte-lane bits of the address are ignored
   assign idx_w       = wb_adr_i[13:2];
   // ack high masks a held request, so it is not taken again in the ack cycle
   assign req_w       = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_w        = req_w & wb_we_i;
   assign rd_w        = req_w & ~wb_we_i;
   assign sel0_w      = wb_sel_i[0];
   assign sel1_w      = wb_sel_i[1];
   assign hit_cfg_w   = (idx_w == IDX_CFG);
   assign hit_coeff_w = (idx_w == IDX_COEFF);

   // ----------------------------------------
   // fuse load strobe
   // ----------------------------------------
   // high on the first edge after release; fuse must be steady then
   always @(posedge clock) begin
      if (!rst_n) begin
         fuse_load_r <= 1'b1;
      end else begin
         fuse_load_r <= 1'b0;
      end
   end

   // ----------------------------------------
   // gain trims
   // ----------------------------------------
   // a write in the fuse load cycle is lost: fuse wins
   genvar g;
   generate
      for (g = 0; g < N_GAIN; g = g + 1) begin : g_gain
         localparam integer IDX = IDX_GAIN0 + g;
         reg [GW-1:0] trim_r;

         assign hit_gain_w[g] = ({20'h00000, idx_w} == IDX);
         assign gain_flat_w[g*GW +: GW] = trim_r;

         always @(posedge clock) begin
            if (!rst_n) begin
               trim_r <= {GW{1'b0}};
            end else if (fuse_load_r) begin
               trim_r <= fuse_gain_i[g*GW +: GW];
            end else if (wr_w && sel0_w && hit_gain_w[g]) begin
               trim_r <= wb_dat_i[GW-1:0];
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // filter config next value
   // ----------------------------------------
   // reserved bit 7 is kept as written, it steers nothing
   always @* begin
      cfg_nxt = cfg_r;
      if (wr_w && sel0_w && hit_cfg_w) begin
         cfg_nxt = wb_dat_i[7:0];
      end
   end

   // ----------------------------------------
   // coefficient next value
   // ----------------------------------------
   // byte lanes written on their own select
   always @* begin
      coeff_nxt = coeff_r;
      if (wr_w && sel0_w && hit_coeff_w) begin
         coeff_nxt[7:0] = wb_dat_i[7:0];
      end
      if (wr_w && sel1_w && hit_coeff_w) begin
         coeff_nxt[15:8] = wb_dat_i[15:8];
      end
   end

   // ----------------------------------------
   // config and coefficient store
   // ----------------------------------------
   always @(posedge clock) begin
      if (!rst_n) begin
         cfg_r   <= `FGF_CFG_RESET;
         coeff_r <= 16'h0000;
      end else begin
         cfg_r   <= cfg_nxt;
         coeff_r <= coeff_nxt;
      end
   end

   // ----------------------------------------
   // config field decode
   // ----------------------------------------
   assign mode_w    = cfg_r[`FGF_CFG_MODE_MSB:0];
   assign share_w   = cfg_r[`FGF_CFG_SHARE_BIT];
   assign merge_w   = cfg_r[`FGF_CFG_MERGE_BIT];
   assign weight_w  = cfg_r[`FGF_CFG_SCW_MSB:`FGF_CFG_SCW_LSB];
   // reserved mode codes leave the filter off, the safe choice
   assign mode_on_w = (mode_w == `FGF_MODE_ON);

   // ----------------------------------------
   // read mux
   // ----------------------------------------
   // unmapped reads return zero; gain bits 7:5 read zero
   always @* begin
      rd_nxt = 32'h0000_0000;
      if (hit_cfg_w) begin
         rd_nxt[7:0] = cfg_r;
      end
      if (hit_coeff_w) begin
         rd_nxt[15:0] = coeff_r;
      end
      for (k = 0; k < N_GAIN; k = k + 1) begin
         if (hit_gain_w[k]) begin
            rd_nxt[GW-1:0] = gain_flat_w[k*GW +: GW];
         end
      end
   end

   // ----------------------------------------
   // bus outputs
   // ----------------------------------------
   // ack is one cycle after the take; data is zero outside a read ack
   always @(posedge clock) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req_w;
         wb_dat_o <= rd_w ? rd_nxt : 32'h0000_0000;
      end
   end

   // ----------------------------------------
   // status outputs
   // ----------------------------------------
   // one edge behind the store; keeps every output on a flip-flop
   always @(posedge clock) begin
      if (!rst_n) begin
         fine_gain_trim_o      <= {GAIN_ALL{1'b0}};
         equaliser_filter_en_o <= 1'b0;
         coeff_share_bit_o     <= 1'b0;
         filter_merge_bit_o    <= 1'b0;
         side_weight_field_o   <= 3'h0;
         coeff_a_tap0_o        <= {COEFF_W{1'b0}};
      end else begin
         fine_gain_trim_o      <= gain_flat_w;
         equaliser_filter_en_o <= mode_on_w;
         coeff_share_bit_o     <= share_w;
         filter_merge_bit_o    <= merge_w;
         side_weight_field_o   <= weight_w;
         coeff_a_tap0_o        <= coeff_r[COEFF_W-1:0];
      end
   end

   // ----------------------------------------
   // limitations
   // ----------------------------------------
   // the filter datapath is outside this block: the outputs only steer it
   // side-weight codes above 6 are stored as written and not trapped
   // the fuse word is read once, it is not watched afterward

endmodule // fgf_regs
`default_nettype wire

// file: testbench/fgf_checker.sv
// assertions for the fgf register bank
`timescale 1ns/1ps
`default_nettype none
module fgf_checker (
   input wire logic        clock,
   input wire logic        rst_n,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic        wb_ack_o,
   input wire logic [13:0] wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [19:0] fuse_gain_i,
   input wire logic [19:0] fine_gain_trim_o,
   input wire logic        equaliser_filter_en_o,
   input wire logic        coeff_share_bit_o,
   input wire logic        filter_merge_bit_o,
   input wire logic [2:0]  side_weight_field_o,
   input wire logic [11:0] coeff_a_tap0_o
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // status lags the store by one edge, so compare two edges on
   logic [45:0] h1_r, h2_r;
   always @(posedge clock) {h2_r, h1_r} <= {h1_r, wb_adr_i, wb_dat_i};
   wire wr = wb_cyc_i & wb_stb_i & wb_we_i & !wb_ack_o & (&wb_sel_i);
   sequence s_w(logic [11:0] i); wr && wb_adr_i[13:2] == i ##2 1; endsequence
   sequence s_g; wr && wb_adr_i[13:4] == 10'h0D5 ##2 1; endsequence
   property p_en; s_w(12'h400) |-> equaliser_filter_en_o == (h2_r[1:0] == 2'h2); endproperty
   a_en: assert property (p_en) else $error("enable wrong");
   property p_sh; s_w(12'h400) |-> coeff_share_bit_o == h2_r[6]; endproperty
   a_sh: assert property (p_sh) else $error("share wrong");
   property p_mg; s_w(12'h400) |-> filter_merge_bit_o == h2_r[5]; endproperty
   a_mg: assert property (p_mg) else $error("merge wrong");
   property p_sw; s_w(12'h400) |-> side_weight_field_o == h2_r[4:2]; endproperty
   a_sw: assert property (p_sw) else $error("weight wrong");
   property p_tp; s_w(12'h418) |-> coeff_a_tap0_o == h2_r[11:0]; endproperty
   a_tp: assert property (p_tp) else $error("tap wrong");
   property p_gn; s_g |-> 5'(fine_gain_trim_o >> 5 * h2_r[35:34]) == h2_r[4:0]; endproperty
   a_gn: assert property (p_gn) else $error("gain wrong");
   property p_fu; $rose(rst_n) ##2 1 |-> fine_gain_trim_o == fuse_gain_i; endproperty
   a_fu: assert property (p_fu) else $error("fuse load wrong");
   property p_rs; $rose(rst_n) |-> {equaliser_filter_en_o, coeff_share_bit_o,
      filter_merge_bit_o, side_weight_field_o} == 6'h00; endproperty
   a_rs: assert property (p_rs) else $error("reset config wrong");
endmodule // fgf_checker
bind fgf_regs fgf_checker chk_u (
   .clock(clock), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .fuse_gain_i(fuse_gain_i), .fine_gain_trim_o(fine_gain_trim_o),
   .equaliser_filter_en_o(equaliser_filter_en_o), .coeff_share_bit_o(coeff_share_bit_o),
   .filter_merge_bit_o(filter_merge_bit_o), .side_weight_field_o(side_weight_field_o),
   .coeff_a_tap0_o(coeff_a_tap0_o));
`default_nettype wire

// file: testbench/testbench.sv
// self-checking bench for the fgf register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clock, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, equaliser_filter_en_o;
   logic coeff_share_bit_o, filter_merge_bit_o;
   logic [2:0] side_weight_field_o;
   logic [3:0] wb_sel_i;
   logic [11:0] coeff_a_tap0_o;
   logic [13:0] wb_adr_i, a;
   logic [13:0] am [7] = '{14'hD50, 14'hD54, 14'hD58, 14'hD5C, 14'h1000, 14'h1060, 14'h0FFC};
   logic [19:0] fuse_gain_i, fine_gain_trim_o;
   logic [31:0] wb_dat_i, wb_dat_o, q, d;
   int seed = 39, n_mismatch = 0, total_checks = 0;
   fgf_regs dut_u (
      .clock(clock), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .fuse_gain_i(fuse_gain_i),
      .fine_gain_trim_o(fine_gain_trim_o), .equaliser_filter_en_o(equaliser_filter_en_o),
      .coeff_share_bit_o(coeff_share_bit_o), .filter_merge_bit_o(filter_merge_bit_o),
      .side_weight_field_o(side_weight_field_o), .coeff_a_tap0_o(coeff_a_tap0_o));
   // reserved bits are written as zero, so masks leave them out
   function automatic logic [31:0] keep(input logic [13:0] x, input logic [31:0] v);
      return v & (x[13:4] == 10'h0D5 ? 32'h1F : x == 14'h1000 ? 32'h7F :
         x == 14'h1060 ? 32'hFFF : 32'h0);
   endfunction
   task automatic chk(input logic [31:0] g, e);
      total_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic bus(input logic w, input logic [13:0] x, input logic [31:0] v);
      int n = 0;
      wb_cyc_i <= 1; wb_stb_i <= 1; wb_we_i <= w; wb_adr_i <= x; wb_dat_i <= v;
      do @(posedge clock); while (wb_ack_o !== 1'b1 && ++n < 20);
      if (n > 19) n_mismatch++;
      q = wb_dat_o;
      wb_cyc_i <= 0; wb_stb_i <= 0;
      @(posedge clock);
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      clock = 0;
      forever #5 clock = ~clock;
   end
   initial begin
      #100000;
      n_mismatch++;
      final_report;
   end
   initial begin
      wb_cyc_i = 0; wb_stb_i = 0; wb_we_i = 0; wb_adr_i = 0; wb_dat_i = 0; rst_n = 0;
      wb_sel_i = 4'hF;
      fuse_gain_i = $random(seed);
      repeat (12) @(posedge clock);
      rst_n <= 1;
      repeat (3) @(posedge clock);
      chk(fine_gain_trim_o, fuse_gain_i);
      bus(0, 14'h1000, 0);
      chk(q, 0);
      for (int i = 0; i < 60; i++) begin
         a = am[i < 7 ? i : {$random(seed)} % 7];
         d = keep(a, $random(seed));
         if (a == 14'h1000 && d[4:2] == 3'h7) d[4:2] = 3'h6;
         bus(1, a, d);
         bus(0, a, 0);
         chk(q, d);
         if (a == 14'h1000) chk({coeff_share_bit_o, filter_merge_bit_o, side_weight_field_o,
            equaliser_filter_en_o}, {d[6:2], d[1:0] == 2'h2});
         if (a == 14'h1060) chk(coeff_a_tap0_o, d[11:0]);
      end
      bus(1, 14'h1060, 32'h800);
      bus(1, 14'h1000, 32'h22);
      chk({coeff_share_bit_o, filter_merge_bit_o, side_weight_field_o,
         equaliser_filter_en_o}, 6'h11);
      chk(coeff_a_tap0_o, 12'h800);
      rst_n <= 0;
      fuse_gain_i <= $random(seed);
      repeat (4) @(posedge clock);
      rst_n <= 1;
      repeat (3) @(posedge clock);
      chk(fine_gain_trim_o, fuse_gain_i);
      bus(0, 14'h1000, 0);
      chk(q, 0);
      bus(0, 14'h1060, 0);
      chk(q, 0);
      final_report;
   end
endmodule // testbench
`default_nettype wire
